// ---- can_map.svh ----
// Notes on behaviour
// - 32 overflow flags over low and high registers; set on store into full buffer.
// - Writing zero clears a flag, writing one does nothing, all flags reset to zero.
// - Word 1 bits 11..0 carry extended identifier bits 17..6, MSB highest.
// - Word 1 bits 15..12 are unused and read as zero.
`ifndef CAN_MAP_SVH
`define CAN_MAP_SVH

// ---------------------------------------------
// Register byte addresses
// ---------------------------------------------
`define CAN_OVF_LO_ADDR 8'h00
`define CAN_OVF_HI_ADDR 8'h04
`define CAN_BASE_ADDR 8'h08
`define CAN_STRIDE_ADDR 8'h0C
`define CAN_IRQ_STAT_ADDR 8'h10
`define CAN_IRQ_CLR_ADDR 8'h14
`define CAN_IRQ_EN_ADDR 8'h18

// ---------------------------------------------
// Reset values
// ---------------------------------------------
`define CAN_OVF_RESET 32'h0000_0000
`define CAN_BASE_RESET 16'h0000
`define CAN_STRIDE_RESET 8'h08
`define CAN_IRQ_RESET 2'h0

// ---------------------------------------------
// Field positions
// ---------------------------------------------
`define CAN_IRQ_OVF_BIT 0
`define CAN_IRQ_STORED_BIT 1
`define CAN_W0_IDE_BIT 0
`define CAN_W0_SRR_BIT 1
`define CAN_W0_SID_LSB 2
`define CAN_W1_EID_MSB 11

`endif

// ---- can_pkg.sv ----
package can_pkg;

  // ---------------------------------------------
  // Received message header
  // ---------------------------------------------
  typedef struct packed {
    logic [10:0] standard_identifier_field;
    logic srr;
    logic ide;
    logic [17:0] extended_identifier_field;
  } can_msg_type;

  // ---------------------------------------------
  // Store sequencer states
  // ---------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_WORD0 = 3'b010,
    ST_WORD1 = 3'b100
  } can_state_type;

endpackage : can_pkg

// ---- can_rx_buffer_overflow_flag.sv ----
// The strobed register port and the register offsets are this design's own decisions.
`timescale 1ns/1ns
`include "can_map.svh"

module can_rx_buffer_overflow_flag (
  // Clock and reset
  input wire logic CLK,
  input wire logic RESET_N,
  // Register port
  input wire logic [7:0] ADDR,
  input wire logic [15:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [15:0] RDATA,
  // Store request from receive engine
  input wire logic STORE_REQ,
  input wire logic [4:0] STORE_BUF,
  input wire logic STORE_FULL,
  input wire can_pkg::can_msg_type STORE_MSG,
  output logic STORE_READY,
  // Buffer RAM write port
  output logic RAM_WE,
  output logic [15:0] RAM_ADDR,
  output logic [15:0] RAM_WDATA,
  // Interrupt
  output logic IRQ
);

  // ---------------------------------------------
  // State
  // ---------------------------------------------
  logic [31:0] ovf_flags, next_ovf_flags;
  logic [15:0] base, next_base;
  logic [7:0] stride, next_stride;
  logic [1:0] irq_stat, next_irq_stat;
  logic [1:0] irq_en, next_irq_en;
  logic next_irq;
  logic [15:0] next_rdata;
  can_pkg::can_state_type state, next_state;
  can_pkg::can_msg_type msg, next_msg;
  logic next_store_ready, next_ram_we;
  logic [15:0] next_ram_addr, next_ram_wdata;
  logic accept;
  logic [31:0] ovf_set;
  logic [1:0] irq_event;

  // Request is taken only while idle; ready tells the engine so
  assign accept = STORE_REQ && STORE_READY;

  // Per-buffer set pulse when the target is still full
  always_comb begin
    ovf_set = 32'h0000_0000;
    if (accept && STORE_FULL) begin
      ovf_set[STORE_BUF] = 1'b1;
    end
  end

  // ---------------------------------------------
  // Overflow flags
  // ---------------------------------------------
  // AND with written data: a zero clears, a one keeps; set wins over clear
  always_comb begin
    next_ovf_flags = ovf_flags;
    if (WR && ADDR == `CAN_OVF_LO_ADDR) begin
      next_ovf_flags[15:0] = ovf_flags[15:0] & WDATA;
    end
    if (WR && ADDR == `CAN_OVF_HI_ADDR) begin
      next_ovf_flags[31:16] = ovf_flags[31:16] & WDATA;
    end
    next_ovf_flags = next_ovf_flags | ovf_set;
  end

  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      ovf_flags <= `CAN_OVF_RESET;
    end else begin
      ovf_flags <= next_ovf_flags;
    end
  end

  // ---------------------------------------------
  // Buffer area setup and interrupt registers
  // ---------------------------------------------
  // Base and stride locate buffers in general RAM
  always_comb begin
    next_base = base;
    next_stride = stride;
    next_irq_en = irq_en;
    irq_event = 2'h0;
    irq_event[`CAN_IRQ_OVF_BIT] = |ovf_set;
    irq_event[`CAN_IRQ_STORED_BIT] = (state == can_pkg::ST_WORD1);
    next_irq_stat = irq_stat;
    if (WR && ADDR == `CAN_BASE_ADDR) begin
      next_base = WDATA;
    end
    if (WR && ADDR == `CAN_STRIDE_ADDR) begin
      next_stride = WDATA[7:0];
    end
    if (WR && ADDR == `CAN_IRQ_EN_ADDR) begin
      next_irq_en = WDATA[1:0];
    end
    if (WR && ADDR == `CAN_IRQ_CLR_ADDR) begin
      next_irq_stat = irq_stat & ~WDATA[1:0];
    end
    next_irq_stat = next_irq_stat | irq_event; // Event beats clear
    next_irq = |(next_irq_stat & next_irq_en);
  end

  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      base <= `CAN_BASE_RESET;
      stride <= `CAN_STRIDE_RESET;
      irq_en <= `CAN_IRQ_RESET;
      irq_stat <= `CAN_IRQ_RESET;
      IRQ <= 1'b0;
    end else begin
      base <= next_base;
      stride <= next_stride;
      irq_en <= next_irq_en;
      irq_stat <= next_irq_stat;
      IRQ <= next_irq;
    end
  end

  // ---------------------------------------------
  // Read port
  // ---------------------------------------------
  // Unmapped and write-only addresses read as zero
  always_comb begin
    next_rdata = 16'h0000;
    if (RD) begin
      unique case (ADDR)
        `CAN_OVF_LO_ADDR: next_rdata = ovf_flags[15:0];
        `CAN_OVF_HI_ADDR: next_rdata = ovf_flags[31:16];
        `CAN_BASE_ADDR: next_rdata = base;
        `CAN_STRIDE_ADDR: next_rdata = {8'h00, stride};
        `CAN_IRQ_STAT_ADDR: next_rdata = {14'h0, irq_stat};
        `CAN_IRQ_EN_ADDR: next_rdata = {14'h0, irq_en};
        default: next_rdata = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      RDATA <= 16'h0000;
    end else begin
      RDATA <= next_rdata;
    end
  end

  // ---------------------------------------------
  // Store sequencer
  // ---------------------------------------------
  // Two RAM writes per message; word contents leave unused bits zero
  always_comb begin
    next_state = state;
    next_msg = msg;
    next_ram_we = 1'b0;
    next_ram_addr = RAM_ADDR;
    next_ram_wdata = RAM_WDATA;
    unique case (state)
      can_pkg::ST_IDLE: begin
        if (accept && !STORE_FULL) begin
          next_msg = STORE_MSG;
          next_msg.srr = STORE_MSG.srr | STORE_MSG.ide;
          next_ram_we = 1'b1;
          next_ram_addr = base + 16'(STORE_BUF) * 16'(stride);
          next_ram_wdata = {3'b000, STORE_MSG.standard_identifier_field, next_msg.srr, STORE_MSG.ide};
          next_state = can_pkg::ST_WORD0;
        end
      end
      can_pkg::ST_WORD0: begin
        next_ram_we = 1'b1;
        next_ram_addr = RAM_ADDR + 16'h0001;
        next_ram_wdata = {4'h0, msg.extended_identifier_field[17:6]};
        next_state = can_pkg::ST_WORD1;
      end
      can_pkg::ST_WORD1: begin
        next_state = can_pkg::ST_IDLE;
      end
      default: begin
        next_state = can_pkg::ST_IDLE;
      end
    endcase
    next_store_ready = (next_state == can_pkg::ST_IDLE);
  end

  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      state <= can_pkg::ST_IDLE;
      msg <= '0;
      STORE_READY <= 1'b1;
      RAM_WE <= 1'b0;
      RAM_ADDR <= 16'h0000;
      RAM_WDATA <= 16'h0000;
    end else begin
      state <= next_state;
      msg <= next_msg;
      STORE_READY <= next_store_ready;
      RAM_WE <= next_ram_we;
      RAM_ADDR <= next_ram_addr;
      RAM_WDATA <= next_ram_wdata;
    end
  end

  // ---------------------------------------------
  // Assertions
  // ---------------------------------------------
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RESET_N);

  sequence s_accept_free;
    STORE_REQ && STORE_READY && !STORE_FULL;
  endsequence

  sequence s_two_writes;
    RAM_WE && state == can_pkg::ST_WORD0 ##1 RAM_WE && RAM_ADDR == $past(RAM_ADDR) + 16'h0001 ##1 !RAM_WE;
  endsequence

  a_flag_sets_full: assert property ((STORE_REQ && STORE_READY && STORE_FULL) |=> ovf_flags[$past(STORE_BUF)])
    else $error("overflow flag not set on full buffer");

  a_one_keeps_flag: assert property ((WR && ADDR == `CAN_OVF_LO_ADDR && WDATA == 16'hFFFF)
    |=> ((ovf_flags[15:0] & $past(ovf_flags[15:0])) == $past(ovf_flags[15:0])))
    else $error("writing one changed an overflow flag");

  a_zero_clears_flag: assert property ((WR && ADDR == `CAN_OVF_HI_ADDR)
    |=> ovf_flags[31:16] == (($past(ovf_flags[31:16]) & $past(WDATA)) | $past(ovf_set[31:16])))
    else $error("writing zero did not clear flags");

  a_store_sequence: assert property (s_accept_free |=> s_two_writes)
    else $error("message store sequence wrong");

  a_store_address: assert property (s_accept_free
    |=> RAM_ADDR == $past(base) + 16'($past(STORE_BUF)) * 16'($past(stride)))
    else $error("buffer address not from base and stride");

  a_word0_layout: assert property (s_accept_free |=> RAM_WDATA[15:13] == 3'b000
    && RAM_WDATA[12:2] == $past(STORE_MSG.standard_identifier_field) && RAM_WDATA[0] == $past(STORE_MSG.ide))
    else $error("word 0 layout wrong");

  a_srr_extended: assert property ((RAM_WE && state == can_pkg::ST_WORD0 && RAM_WDATA[`CAN_W0_IDE_BIT])
    |-> RAM_WDATA[`CAN_W0_SRR_BIT])
    else $error("remote request bit clear in extended frame");

  a_word1_layout: assert property (s_accept_free
    |=> ##1 RAM_WDATA == {4'h0, $past(STORE_MSG.extended_identifier_field[17:6], 2)})
    else $error("word 1 layout wrong");

  a_irq_follows: assert property ((STORE_REQ && STORE_READY && STORE_FULL && irq_en[`CAN_IRQ_OVF_BIT] && !WR) |=> IRQ)
    else $error("interrupt not raised for enabled status");

endmodule : can_rx_buffer_overflow_flag

// ---- can_ram_model.sv ----
`timescale 1ns/1ns
module can_ram_model (
  // Write side
  input wire logic clk,
  input wire logic we,
  input wire logic [15:0] addr,
  input wire logic [15:0] wdata
);
  logic [15:0] mem [65536];
  // Plain RAM words, unknown until first written
  always @(posedge clk) begin
    if (we) begin
      mem[addr] <= wdata;
    end
  end
endmodule : can_ram_model

// ---- can_rx_overflow_and_msg_buffer_tb.sv ----
`timescale 1ns/1ns
`include "can_map.svh"
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin failures++; \
  $display("MISMATCH %s exp %h got %h", nm, e, g); end end
module can_rx_overflow_and_msg_buffer_tb;
  logic CLK = 1'b0, RESET_N = 1'b0, WR = 1'b0, RD = 1'b0, STORE_REQ = 1'b0, STORE_FULL = 1'b0;
  logic [7:0] ADDR = 8'h00;
  logic [4:0] STORE_BUF = 5'h00;
  can_pkg::can_msg_type STORE_MSG = '0;
  logic [15:0] WDATA = 16'h0000, RDATA, RAM_ADDR, RAM_WDATA, base, stride, a, d;
  logic STORE_READY, RAM_WE, IRQ;
  // Reference model state
  logic [31:0] ovf = 32'h0000_0000;
  logic [1:0] st = 2'h0;
  logic [7:0] seed = 8'h24;
  logic [4:0] b, edge_bufs [4] = '{5'h00, 5'h0F, 5'h10, 5'h1F};
  can_pkg::can_msg_type m;
  int failures = 0, num_checks = 0, cycles = 0;
  // ------------
  // Design, far side and clock
  // ------------
  can_rx_buffer_overflow_flag dut (.CLK(CLK), .RESET_N(RESET_N), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD),
    .RDATA(RDATA), .STORE_REQ(STORE_REQ), .STORE_BUF(STORE_BUF), .STORE_FULL(STORE_FULL),
    .STORE_MSG(STORE_MSG), .STORE_READY(STORE_READY), .RAM_WE(RAM_WE), .RAM_ADDR(RAM_ADDR),
    .RAM_WDATA(RAM_WDATA), .IRQ(IRQ));
  can_ram_model ram (.clk(CLK), .we(RAM_WE), .addr(RAM_ADDR), .wdata(RAM_WDATA));
  always #5 CLK = ~CLK;
  // Hang guard
  always @(posedge CLK) begin
    cycles++;
    if (cycles == 3000) begin
      failures++;
      give_verdict();
    end
  end
  // ------------
  // Helpers
  // ------------
  function automatic logic [7:0] lfsr(input logic [7:0] v);
    return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
  endfunction : lfsr
  task give_verdict();
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : give_verdict
  task wr(input logic [7:0] ad, input logic [15:0] dt);
    @(posedge CLK);
    WR <= 1'b1;
    ADDR <= ad;
    WDATA <= dt;
    @(posedge CLK);
    WR <= 1'b0;
  endtask : wr
  // Read data stands only in the cycle after the strobe
  task rdchk(input logic [7:0] ad, input logic [15:0] e, input string nm);
    @(posedge CLK);
    RD <= 1'b1;
    ADDR <= ad;
    @(posedge CLK);
    RD <= 1'b0;
    #1;
    `CHK(nm, e, RDATA)
  endtask : rdchk
  // Next call waits until ready is back
  task store(input logic [4:0] bf, input logic f, input can_pkg::can_msg_type mg);
    @(posedge CLK);
    STORE_REQ <= 1'b1;
    STORE_BUF <= bf;
    STORE_FULL <= f;
    STORE_MSG <= mg;
    @(posedge CLK);
    STORE_REQ <= 1'b0;
    STORE_BUF <= ~bf;
    STORE_FULL <= ~f;
    STORE_MSG <= ~mg;
    if (!f) begin
      @(posedge CLK) #1 `CHK("busy", 1'b0, STORE_READY)
      @(posedge CLK);
      st[1] = 1'b1;
    end else begin
      ovf[bf] = 1'b1;
      st[0] = 1'b1;
    end
  endtask : store
  // ------------
  // Main sequence
  // ------------
  initial begin
    repeat (12) @(posedge CLK);
    RESET_N <= 1'b1;
    rdchk(`CAN_OVF_LO_ADDR, 16'h0000, "flags_low");
    rdchk(`CAN_OVF_HI_ADDR, 16'h0000, "flags_high");
    wr(`CAN_IRQ_EN_ADDR, 16'h0001);
    // Overflow into edge buffers, then random ones, with one idle cycle between requests
    for (int i = 0; i < 12; i++) begin
      seed = lfsr(seed);
      b = (i < 4) ? edge_bufs[i] : seed[4:0];
      store(b, 1'b1, {seed, seed, seed, seed[6:0]});
    end
    rdchk(`CAN_OVF_LO_ADDR, ovf[15:0], "flags_low");
    rdchk(`CAN_OVF_HI_ADDR, ovf[31:16], "flags_high");
    `CHK("irq_on", 1'b1, IRQ)
    wr(`CAN_OVF_LO_ADDR, 16'hFFFF);
    rdchk(`CAN_OVF_LO_ADDR, ovf[15:0], "ones_ignored");
    seed = lfsr(seed);
    d = {seed, ~seed};
    wr(`CAN_OVF_HI_ADDR, d);
    ovf[31:16] = ovf[31:16] & d;
    rdchk(`CAN_OVF_HI_ADDR, ovf[31:16], "zero_clears");
    wr(`CAN_IRQ_CLR_ADDR, 16'h0001);
    st[0] = 1'b0;
    // Buffer words for every format and remote combination
    seed = lfsr(seed);
    base = {8'h01, seed};
    stride = {12'h000, seed[3:0]} | 16'h0002;
    wr(`CAN_BASE_ADDR, base);
    wr(`CAN_STRIDE_ADDR, stride);
    rdchk(`CAN_BASE_ADDR, base, "base");
    for (int j = 0; j < 4; j++) begin
      seed = lfsr(seed);
      m = {seed[2:0], seed, j[1], j[0], seed[1:0], ~seed, seed};
      b = seed[4:0];
      store(b, 1'b0, m);
      #1;
      a = base + b * stride;
      `CHK("word0", {3'h0, m.standard_identifier_field, m.srr | m.ide, m.ide}, ram.mem[a])
      `CHK("word1", {4'h0, m.extended_identifier_field[17:6]}, ram.mem[a + 16'h0001])
    end
    rdchk(`CAN_OVF_HI_ADDR, ovf[31:16], "no_flag_when_room");
    rdchk(`CAN_IRQ_STAT_ADDR, {14'h0, st}, "irq_status");
    `CHK("irq_off", 1'b0, IRQ)
    wr(`CAN_IRQ_EN_ADDR, 16'h0002);
    rdchk(8'h1C, 16'h0000, "unmapped");
    `CHK("irq_stored", 1'b1, IRQ)
    give_verdict();
  end
endmodule : can_rx_overflow_and_msg_buffer_tb
